/* File: verilog/ass_pkg.sv */
// Purpose: Constants and types for the converter sequencing block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package ass_pkg;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TIMING   = 8'h04;
  localparam logic [7:0] OFF_CHAN     = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_TESTFLG  = 8'h10;
  localparam logic [7:0] OFF_RESULT0  = 8'h20;
  localparam logic [7:0] OFF_RES_MASK = 8'hE0;
  // Channel control field positions
  localparam int CH_CODE_LSB   = 0;
  localparam int CH_SPECIAL    = 4;
  localparam int CH_MULTI      = 5;
  localparam int CH_SINGLE     = 6;
  localparam int CH_EIGHT      = 7;
  // Control register field positions
  localparam int CT_SCAN       = 0;
  localparam int CT_FAST_CLEAR = 1;
  localparam int CT_FIFO       = 2;
  localparam int CT_IRQ_EN     = 3;
  localparam int CT_TEST_MODE  = 4;
  // Status field positions
  localparam int ST_CNT_LSB    = 0;
  localparam int ST_SEQ_DONE   = 7;
  localparam int ST_FLAGS_LSB  = 8;
  // Reset values and sequence lengths
  localparam logic [7:0]  RST_CHAN   = 8'h00;
  localparam logic [4:0]  RST_CTRL   = 5'h00;
  localparam logic [7:0]  RST_TIMING = 8'h01;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [3:0]  LEN_ONE    = 4'h1;
  localparam logic [3:0]  LEN_FOUR   = 4'h4;
  localparam logic [3:0]  LEN_EIGHT  = 4'h8;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} ass_seq_t;

  typedef struct packed {
    logic [2:0]  channel;
    logic        special;
  } ass_conv_req_t;

  typedef struct packed {
    ass_seq_t            seq;
    logic [7:0]          chan;
    logic [4:0]          ctrl;
    logic [7:0]          timing;
    logic [2:0]          code;
    logic [2:0]          counter;
    logic [3:0]          done_cnt;
    logic                seq_done;
    logic [7:0]          flags;
    logic [7:0]          armed;
    logic [7:0][15:0]    results;
    logic                start_o;
    ass_conv_req_t       req;
    logic [31:0]         rdata;
    logic                ack;
  } ass_state_t;
endpackage : ass_pkg

/* File: verilog/ass_seq_status.sv */
// Purpose: Sequencing, result mapping and status flags of an 8-input ADC
// Assumes: Converter core takes a start pulse, answers with done and data
// Notes:   Registers over APB; one wait state, pslverr on bad address
`timescale 1ns/1ns
module ass_seq_status
  import ass_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic                      conv_start_o,
  output ass_pkg::ass_conv_req_t    conv_req_o,
  input  wire logic                 conv_done_i,
  input  wire logic [15:0]          conv_data_i,
  output logic                      irq_o
);
  import ass_pkg::*;

  ass_state_t s_q;
  ass_state_t s_d;

  logic       acc;
  logic       wr;
  logic       rd;
  logic       is_res;
  logic [2:0] res_idx;
  logic       legal;
  logic [3:0] seq_len;
  logic       restart;
  logic       xfer;
  logic       first;
  logic       take;
  logic       last;

  function automatic logic [2:0] inc3(input logic [2:0] v);
    inc3 = 3'(v + 3'h1);
  endfunction

  function automatic logic [3:0] len_of(input logic [7:0] c);
    if (c[CH_EIGHT]) begin
      len_of = LEN_EIGHT;
    end else if (c[CH_SINGLE]) begin
      len_of = LEN_ONE;
    end else begin
      len_of = LEN_FOUR;
    end
  endfunction

  function automatic logic hits_result(input logic [7:0] a);
    hits_result = (a & OFF_RES_MASK) == OFF_RESULT0;
  endfunction

  function automatic logic hits_plain(input logic [7:0] a);
    unique case (a)
      OFF_CTRL,
      OFF_TIMING,
      OFF_CHAN,
      OFF_STATUS,
      OFF_TESTFLG: hits_plain = 1'b1;
      default:     hits_plain = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] status_word(input ass_state_t st);
    status_word = 32'h0000_0000;
    status_word[ST_CNT_LSB +: 3]   = st.counter;
    status_word[ST_SEQ_DONE]       = st.seq_done;
    status_word[ST_FLAGS_LSB +: 8] = st.flags;
  endfunction

  function automatic logic [31:0] read_word(input ass_state_t st,
                                            input logic [7:0] a);
    read_word = 32'h0000_0000;
    if (hits_result(a)) begin
      read_word[15:0] = st.results[a[4:2]];
    end else begin
      unique case (a)
        OFF_CTRL:    read_word[4:0] = st.ctrl;
        OFF_TIMING:  read_word[7:0] = st.timing;
        OFF_CHAN:    read_word[7:0] = st.chan;
        OFF_STATUS:  read_word      = status_word(st);
        OFF_TESTFLG: read_word[7:0] = st.flags;
        default:     read_word      = 32'h0000_0000;
      endcase
    end
  endfunction

  // First access cycle fetches, second one completes with pready
  assign acc     = psel_i & penable_i;
  assign first   = acc & ~s_q.ack;
  assign xfer    = acc & s_q.ack;
  assign wr      = xfer & pwrite_i;
  assign rd      = xfer & ~pwrite_i;
  assign is_res  = hits_result(paddr_i);
  assign res_idx = paddr_i[4:2];
  assign legal   = is_res | hits_plain(paddr_i);
  assign seq_len = len_of(s_q.chan);
  // A done beside a start pulse belongs to an aborted conversion
  assign take    = (s_q.seq == ST_WAIT) & conv_done_i & ~s_q.start_o;
  assign last    = 4'(s_q.done_cnt + 4'h1) == seq_len;

  always_comb begin
    s_d = s_q;
    restart = 1'b0;
    s_d.start_o = 1'b0;
    s_d.rdata = 32'h0000_0000;
    s_d.ack = first;

    // Sequence engine
    unique case (s_q.seq)
      ST_IDLE: begin
      end
      ST_REQ: begin
        s_d.start_o = 1'b1;
        s_d.req.channel = s_q.code;
        s_d.req.special = s_q.chan[CH_SPECIAL];
        s_d.seq = ST_WAIT;
      end
      ST_WAIT: begin
        if (take) begin
          s_d.results[s_q.counter] = conv_data_i;
          s_d.flags[s_q.done_cnt[2:0]] = 1'b1;
          s_d.armed[s_q.done_cnt[2:0]] = 1'b0;
          s_d.counter = inc3(s_q.counter);
          s_d.done_cnt = 4'(s_q.done_cnt + 4'h1);
          if (s_q.chan[CH_MULTI]) begin
            s_d.code = inc3(s_q.code);
          end else begin
            s_d.code = s_q.chan[CH_CODE_LSB +: 3];
          end
          if (last) begin
            s_d.seq_done = 1'b1;
            if (s_q.ctrl[CT_SCAN]) begin
              restart = 1'b1;
            end else begin
              s_d.seq = ST_IDLE;
            end
          end else begin
            s_d.seq = ST_REQ;
          end
        end
      end
    endcase

    // Read data captured in first cycle, stands with pready
    if (first && !pwrite_i) begin
      s_d.rdata = read_word(s_q, paddr_i);
    end

    // Read side effects, and the armed clear on any result access, land on the completing edge only
    if (rd && is_res && s_q.ctrl[CT_FAST_CLEAR]) begin
      s_d.flags[res_idx] = 1'b0;
      s_d.seq_done = 1'b0;
    end
    if (rd && paddr_i == OFF_STATUS) begin
      s_d.armed = s_q.rdata[ST_FLAGS_LSB +: 8];
    end
    if (xfer && is_res && !s_q.ctrl[CT_FAST_CLEAR]
        && s_q.armed[res_idx]) begin
      s_d.flags[res_idx] = 1'b0;
      s_d.armed[res_idx] = 1'b0;
    end

    // Completing conversion outranks a software clear
    if (take) begin
      s_d.flags[s_q.done_cnt[2:0]] = 1'b1;
      s_d.armed[s_q.done_cnt[2:0]] = 1'b0;
      if (last) begin
        s_d.seq_done = 1'b1;
      end
    end

    // Register writes; status offset ignores writes
    if (wr) begin
      if (paddr_i == OFF_CTRL) begin
        s_d.ctrl = pwdata_i[4:0];
      end else if (paddr_i == OFF_TESTFLG && s_q.ctrl[CT_TEST_MODE]) begin
        s_d.flags = pwdata_i[7:0];
      end else if (paddr_i == OFF_CHAN || paddr_i == OFF_TIMING) begin
        if (paddr_i == OFF_CHAN) begin
          s_d.chan = pwdata_i[7:0];
        end else begin
          s_d.timing = pwdata_i[7:0];
        end
        s_d.flags = 8'h00;
        s_d.armed = 8'h00;
        s_d.seq_done = 1'b0;
        if (!s_q.ctrl[CT_FIFO]) begin
          s_d.counter = 3'h0;
        end
        s_d.done_cnt = 4'h0;
        s_d.code = (paddr_i == OFF_CHAN) ? pwdata_i[2:0]
                                          : s_q.chan[CH_CODE_LSB +: 3];
        s_d.seq = ST_REQ;
        restart = 1'b0;
      end
    end

    // Scan restart of an identical sequence
    if (restart) begin
      if (!s_q.ctrl[CT_FIFO]) begin
        s_d.counter = 3'h0;
      end
      s_d.done_cnt = 4'h0;
      s_d.flags = 8'h00;
      s_d.flags[s_q.done_cnt[2:0]] = 1'b1;
      s_d.code = s_q.chan[CH_CODE_LSB +: 3];
      s_d.seq = ST_REQ;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.seq <= ST_IDLE;
      s_q.chan <= RST_CHAN;
      s_q.ctrl <= RST_CTRL;
      s_q.timing <= RST_TIMING;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o     = s_q.rdata;
  assign pready_o     = s_q.ack;
  assign pslverr_o    = s_q.ack & ~legal;
  assign conv_start_o = s_q.start_o;
  assign conv_req_o   = s_q.req;
  assign irq_o        = s_q.seq_done & s_q.ctrl[CT_IRQ_EN];
endmodule // ass_seq_status

/* File: testbench/ass_seq_status_properties.sv */
// Purpose: Port checks for the sequencer
// Assumes: One conversion outstanding
// Notes:   Bound below
`timescale 1ns/1ns
module ass_chk
  import ass_pkg::*;
(
  input wire logic                   ref_clk_i,
  input wire logic                   rst_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [7:0]             paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic                   pready_o,
  input wire logic                   conv_start_o,
  input wire ass_pkg::ass_conv_req_t conv_req_o,
  input wire logic                   conv_done_i,
  input wire logic                   irq_o
);
  logic [7:0] ch_q;
  logic [4:0] ct_q;
  logic       wr;
  logic       sw;
  logic       rres;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign sw = wr && (paddr_i == OFF_CHAN || paddr_i == OFF_TIMING);
  assign rres = psel_i && penable_i && pready_o && !pwrite_i
      && (paddr_i & OFF_RES_MASK) == OFF_RESULT0;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_q <= 8'h00;
      ct_q <= 5'h00;
    end else if (wr && paddr_i == OFF_CHAN) begin
      ch_q <= pwdata_i[7:0];
    end else if (wr && paddr_i == OFF_CTRL) begin
      ct_q <= pwdata_i[4:0];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_step;
    conv_start_o && ch_q[CH_MULTI] && !$past(sw);
  endsequence
  a_start_on_write: assert property (sw |-> ##2 conv_start_o)
    else $error("no start");
  a_req_code: assert property (wr && paddr_i == OFF_CHAN |-> ##2
    conv_req_o == {$past(pwdata_i[2:0], 2), $past(pwdata_i[CH_SPECIAL], 2)})
    else $error("bad request code");
  a_single_chan: assert property (conv_start_o && !ch_q[CH_MULTI]
    |-> conv_req_o == {ch_q[2:0], ch_q[CH_SPECIAL]})
    else $error("channel moved");
  a_multi_step: assert property (s_step |->
    conv_req_o.channel == $past(conv_req_o.channel) + 3'h1
    || conv_req_o.channel == ch_q[2:0])
    else $error("bad step");
  a_done_irq: assert property (ct_q[CT_IRQ_EN] && ch_q[CH_SINGLE]
    && !ch_q[CH_EIGHT] && conv_done_i && !conv_start_o && !sw
    |-> ##[1:2] irq_o)
    else $error("no irq");
  a_irq_en: assert property (irq_o |-> ct_q[CT_IRQ_EN])
    else $error("irq unmasked");
  a_fast_clear: assert property (ct_q[CT_FAST_CLEAR] && rres
    && !conv_done_i |=> !irq_o)
    else $error("fast clear");
  a_write_clears: assert property (sw |=> !irq_o)
    else $error("irq kept");
endmodule // ass_chk
bind ass_seq_status ass_chk u_ass_chk (
  .ref_clk_i   (ref_clk_i),
  .rst_i       (rst_i),
  .psel_i      (psel_i),
  .penable_i   (penable_i),
  .pwrite_i    (pwrite_i),
  .paddr_i     (paddr_i),
  .pwdata_i    (pwdata_i),
  .pready_o    (pready_o),
  .conv_start_o(conv_start_o),
  .conv_req_o  (conv_req_o),
  .conv_done_i (conv_done_i),
  .irq_o       (irq_o)
);

/* File: testbench/ass_conv_model.sv */
// Purpose: Converter core model
// Assumes: Each start restarts it
// Notes:   Result encodes request
`timescale 1ns/1ns
module ass_conv_model
  import ass_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   slow_i,
  input  wire logic                   start_i,
  input  wire ass_pkg::ass_conv_req_t req_i,
  output logic                        done_o,
  output logic [15:0]                 data_o
);
  logic [3:0] wait_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 4'h0;
      done_o <= 1'h0;
      data_o <= 16'h0000;
    end else begin
      done_o <= wait_q == 4'h1 && !start_i;
      data_o <= ~data_o;
      if (start_i) begin
        wait_q <= slow_i ? 4'hF : 4'h1;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      if (wait_q == 4'h1 && !start_i) begin
        data_o <= {8'hA5, 3'h0, req_i.special, 1'h0, req_i.channel};
      end
    end
  end
endmodule // ass_conv_model

/* File: testbench/test_ass_seq_status.sv */
// Purpose: Self-checking bench
// Assumes: Read data taken at the pready edge
// Notes:   Core fast or slow
`timescale 1ns/1ns
module test_ass_seq_status;
  import ass_pkg::*;
  logic          ref_clk_i = 1'h0, rst_i = 1'h1, slow_q = 1'h0;
  logic          psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [7:0]    paddr_i = 8'h00, m, fl;
  logic [31:0]   pwdata_i = 32'h0, prdata_o, rd;
  logic          pready_o, pslverr_o, conv_start_o, conv_done_i, irq_o, err;
  logic [15:0]   conv_data_i;
  logic [2:0]    c;
  ass_conv_req_t conv_req_o;
  int            n, fails = 0, tests_run = 0;
  logic [7:0]    modes [6] = '{8'h45, 8'h26, 8'hB4, 8'hC3, 8'h35, 8'h02};
  always #2 ref_clk_i = ~ref_clk_i;
  ass_seq_status u_ass_seq_status (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .prdata_o    (prdata_o),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .conv_start_o(conv_start_o),
    .conv_req_o  (conv_req_o),
    .conv_done_i (conv_done_i),
    .conv_data_i (conv_data_i),
    .irq_o       (irq_o)
  );
  ass_conv_model u_ass_conv_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .slow_i(slow_q), .start_i(conv_start_o), .req_i(conv_req_o),
    .done_o(conv_done_i), .data_o(conv_data_i));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'h1 && k < 20);
    chk({31'h0, pready_o}, 32'h1);
    if (k == 20)
      final_report();
    err = pslverr_o;
    rd = prdata_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wirq();
    int k;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (irq_o !== 1'h1 && k < 500);
    chk({31'h0, irq_o}, 32'h1);
    if (k == 500)
      final_report();
  endtask
  function automatic logic [31:0] fx(input logic [2:0] ch, input logic sp);
    return {16'h0, 8'hA5, 3'h0, sp, 1'h0, ch};
  endfunction
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_TIMING, {24'h0, RST_TIMING});
    rdc(8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    bus(1'h1, OFF_CTRL, 32'h08);
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      n = m[7] ? 8 : (m[6] ? 1 : 4);
      fl = (n == 8) ? 8'hFF : 8'((1 << n) - 1);
      bus(1'h1, OFF_CHAN, {24'h0, m});
      wirq();
      rdc(OFF_RESULT0, fx(m[2:0], m[4]));
      rdc(OFF_STATUS, {16'h0, fl, 1'h1, 4'h0, n[2:0]});
      for (int k = 0; k < n; k++) begin
        c = m[2:0] + (m[5] ? 3'(k) : 3'h0);
        rdc(OFF_RESULT0 + 8'(4 * k), fx(c, m[4]));
      end
      rdc(OFF_STATUS, {24'h0, 1'h1, 4'h0, n[2:0]});
    end
    bus(1'h1, OFF_CTRL, 32'h0A);
    bus(1'h1, OFF_CHAN, 32'h26);
    wirq();
    rdc(OFF_RESULT0 + 8'h08, fx(3'h0, 1'h0));
    @(negedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rdc(OFF_STATUS, 32'h0B04);
    bus(1'h1, OFF_CTRL, 32'h0C);
    for (int k = 4; k < 6; k++) begin
      bus(1'h1, OFF_CHAN, 32'(64 + k));
      wirq();
      rdc(OFF_RESULT0 + 8'(4 * k), fx(3'(k), 1'h0));
    end
    bus(1'h1, OFF_CTRL, 32'h08);
    @(posedge ref_clk_i);
    slow_q <= 1'h1;
    bus(1'h1, OFF_TIMING, 32'h01);
    bus(1'h1, OFF_STATUS, 32'hFFFF);
    bus(1'h1, OFF_TESTFLG, 32'hFF);
    rdc(OFF_STATUS, 32'h0);
    bus(1'h1, OFF_CHAN, 32'h41);
    wirq();
    rdc(OFF_STATUS, 32'h0181);
    bus(1'h1, OFF_CTRL, 32'h18);
    bus(1'h1, OFF_TESTFLG, 32'h5A);
    rdc(OFF_TESTFLG, 32'h5A);
    @(posedge ref_clk_i);
    slow_q <= 1'h0;
    bus(1'h1, OFF_CTRL, 32'h09);
    bus(1'h1, OFF_CHAN, 32'h45);
    wirq();
    n = 0;
    repeat (40) begin
      @(negedge ref_clk_i);
      n += int'(conv_start_o);
    end
    chk(32'(n > 2), 32'h1);
    final_report();
  end
endmodule // test_ass_seq_status
